// ==== hw/asr_dev.sv ====
// Purpose: Converter end of the serial result readout
// Assumes: Host masters the serial clock and keeps it low between reads
// Notes: Link logic runs on the serial clock, control on core_clk
// Function
// [R1] Shift bit on rise, host samples fall
// [R2] Host gives sixteen clocks per read
// [R3] Four zeros, then result MSB first
// [R4] Result LSB leaves on last rise
// [R5] Release data line on sixteenth fall
// [R6] Host parks clock low after read
// [R7] Surplus clocks restart word, line stays driven
// [R8] Clock low when start falls after surplus
// [R9] Host may pause read with clock low
// [R10] Load output word at conversion end
// [R11] Defer load while read in progress
// [R12] Start fall loads deferred word, clears count
// [R13] Long start pulse after interrupted read
// [R14] Short start pulse otherwise suffices
// [R15] Edge counter selects presented bit
// [R16] Start fall clears counter if clock low
// [R17] Host avoids start fall during read
// [R18] Device is slave, host makes clocks
// [R19] Host gates clock with select
// [R20] Host port uses polarity zero, phase one
// [R21] Host watches start line for completion; host instead times it from its own start rise
// [R22] Result ready six microseconds after rise
// [R23] Serial clock at most 8.33 MHz
`timescale 1ns/1ps
module asr_dev (
	input wire logic core_clk,
	input wire logic nrst,
	asr_if.dev lnk,
	input wire logic [11:0] result_in,
	output logic converting,
	output logic word_loaded
);

	// ---------------------------------------------------------------
	// Core domain: synchronisers
	// ---------------------------------------------------------------
	logic cs_s;
	logic sck_s;
	logic st_s;
	logic dn_s;
	logic st_tgl_r;
	logic dn_tgl_r;

	asr_sync #(.RST_VAL(1'b1)) u_sync_cs (
		.clk(core_clk),
		.nrst(nrst),
		.d(lnk.convert_start_n),
		.q(cs_s)
	);
	asr_sync #(.RST_VAL(1'b0)) u_sync_sck (
		.clk(core_clk),
		.nrst(nrst),
		.d(lnk.serial_clock_in),
		.q(sck_s)
	);
	asr_sync #(.RST_VAL(1'b0)) u_sync_st (
		.clk(core_clk),
		.nrst(nrst),
		.d(st_tgl_r),
		.q(st_s)
	);
	asr_sync #(.RST_VAL(1'b0)) u_sync_dn (
		.clk(core_clk),
		.nrst(nrst),
		.d(dn_tgl_r),
		.q(dn_s)
	);

	// ---------------------------------------------------------------
	// Core domain: events
	// ---------------------------------------------------------------
	logic cs_d_r;
	logic st_d_r;
	logic dn_d_r;
	logic busy_r;
	logic pend_r;
	logic epoch_r;
	asr_pkg::asr_tmr_t conv_cnt_r;
	logic [11:0] res_r;
	logic [15:0] word_r;

	wire cs_fall = cs_d_r & ~cs_s;
	wire cs_rise = ~cs_d_r & cs_s;
	wire start_ev = st_s ^ st_d_r;
	wire done_ev = dn_s ^ dn_d_r;
	wire eoc = converting & (conv_cnt_r == asr_pkg::TMR_ZERO);
	wire read_end = done_ev & busy_r;
	// Counter restart: idle clock, or deferred load pending
	wire epoch_bump = cs_fall & (~sck_s | pend_r); // [R16] [R12]
	wire load_now = eoc & ~busy_r; // [R10]
	wire load_late = pend_r & (read_end | cs_fall); // [R11] [R12]
	wire [11:0] load_val = eoc ? result_in : res_r;
	wire busy_nxt = start_ev ? 1'b1 : ((done_ev | epoch_bump) ? 1'b0 : busy_r);
	wire pend_nxt = (eoc & busy_r) ? 1'b1 : (load_late ? 1'b0 : pend_r);

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			cs_d_r <= 1'b1;
			st_d_r <= 1'b0;
			dn_d_r <= 1'b0;
			busy_r <= 1'b0;
			pend_r <= 1'b0;
		end else begin
			cs_d_r <= cs_s;
			st_d_r <= st_s;
			dn_d_r <= dn_s;
			busy_r <= busy_nxt;
			pend_r <= pend_nxt; // [R11]
		end
	end

	// ---------------------------------------------------------------
	// Core domain: conversion timer and output word
	// ---------------------------------------------------------------
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			converting <= 1'b0;
			conv_cnt_r <= asr_pkg::TMR_ZERO;
		end else if (cs_rise) begin
			converting <= 1'b1;
			conv_cnt_r <= asr_pkg::CONV_LOAD; // [R22]
		end else if (eoc) begin
			converting <= 1'b0;
		end else if (converting) begin
			conv_cnt_r <= conv_cnt_r - 10'h001;
		end
	end

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			res_r <= asr_pkg::RES_RST;
			word_r <= asr_pkg::WORD_RST;
			word_loaded <= 1'b0;
			epoch_r <= 1'b0;
		end else begin
			if (eoc) begin
				res_r <= result_in;
			end
			if (load_now | load_late) begin
				word_r <= {asr_pkg::LEAD_ZEROS, load_val}; // [R3]
			end
			word_loaded <= load_now | load_late;
			if (epoch_bump) begin
				epoch_r <= ~epoch_r;
			end
		end
	end

	// ---------------------------------------------------------------
	// Link domain: rising edges launch data
	// ---------------------------------------------------------------
	// word_r and epoch_r change while the serial clock is parked low, or with it
	// high on a start fall that finds a deferred load pending.
	logic ep_seen_r;
	logic surplus_r;
	logic bit_r;
	logic on_par_r;
	logic off_par_r;
	asr_pkg::asr_cnt_t cnt_r;

	wire new_ep = ep_seen_r ^ epoch_r;
	wire surp_eff = surplus_r & ~new_ep;
	wire [4:0] idx = new_ep ? asr_pkg::CNT_ZERO : cnt_r;
	wire line_on = on_par_r ^ off_par_r;
	wire frame_start = (idx == asr_pkg::CNT_ZERO) & ~surp_eff;

	always_ff @(posedge lnk.serial_clock_in or negedge nrst) begin
		if (!nrst) begin
			ep_seen_r <= 1'b0;
			cnt_r <= asr_pkg::CNT_ZERO;
			bit_r <= 1'b0;
			surplus_r <= 1'b0;
			on_par_r <= 1'b0;
			st_tgl_r <= 1'b0;
		end else begin
			ep_seen_r <= epoch_r;
			cnt_r <= idx + asr_pkg::CNT_ONE; // [R15]
			bit_r <= asr_pkg::word_bit(word_r, idx); // [R1] [R3] [R4] [R7]
			surplus_r <= surp_eff | idx[4]; // [R7]
			if (!line_on) begin
				on_par_r <= ~on_par_r;
			end
			if (frame_start) begin
				st_tgl_r <= ~st_tgl_r;
			end
		end
	end

	// ---------------------------------------------------------------
	// Link domain: falling edges end the frame
	// ---------------------------------------------------------------
	wire last_fall = (cnt_r == asr_pkg::FRAME_END) & ~surplus_r;

	always_ff @(negedge lnk.serial_clock_in or negedge nrst) begin
		if (!nrst) begin
			off_par_r <= 1'b0;
			dn_tgl_r <= 1'b0;
		end else if (last_fall) begin
			off_par_r <= on_par_r; // [R5]
			dn_tgl_r <= ~dn_tgl_r;
		end
	end

	// Enable is the parity of two link flops; a single flop cannot
	// switch on at a rise and off at a fall.
	assign lnk.serial_data_out = bit_r;
	assign lnk.serial_data_oe = line_on; // [R5] [R7] [R18]

endmodule // asr_dev

// ==== hw/asr_pkg.sv ====
// Purpose: Shared constants and types for the serial result readout link
// Assumes: core_clk at 100 MHz on both ends
// Notes: All times are in ns; cycle counts derive from them
package asr_pkg;

	// ---------------------------------------------------------------
	// Timing
	// ---------------------------------------------------------------
	localparam int CLK_NS = 10;
	localparam int CONV_NS = 6000;
	localparam int CONV_CYC = (CONV_NS + CLK_NS - 1) / CLK_NS;
	localparam int CS_LOW_NS = 1600;
	localparam int CS_LOW_CYC = (CS_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int HALF_NS = 70;
	localparam int HALF_CYC = (HALF_NS + CLK_NS - 1) / CLK_NS;

	typedef logic [9:0] asr_tmr_t;
	localparam asr_tmr_t CONV_LOAD = asr_tmr_t'(CONV_CYC - 1);
	localparam asr_tmr_t CS_LOW_LOAD = asr_tmr_t'(CS_LOW_CYC - 1);
	localparam asr_tmr_t HALF_LOAD = asr_tmr_t'(HALF_CYC - 1);
	localparam asr_tmr_t TMR_ZERO = 10'h000;

	// ---------------------------------------------------------------
	// Word layout and counts
	// ---------------------------------------------------------------
	typedef logic [4:0] asr_cnt_t;
	localparam asr_cnt_t CNT_ZERO = 5'h00;
	localparam asr_cnt_t CNT_ONE = 5'h01;
	localparam asr_cnt_t FRAME_END = 5'h10;
	localparam logic [3:0] LEAD_ZEROS = 4'h0;
	localparam logic [11:0] RES_RST = 12'h000;
	localparam logic [15:0] WORD_RST = 16'h0000;

	// ---------------------------------------------------------------
	// Host sequencer
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		HS_IDLE = 3'b000,
		HS_CNV = 3'b001,
		HS_WAIT = 3'b010,
		HS_HI = 3'b011,
		HS_LO = 3'b100
	} asr_hst_t;

	// Bit of the output word presented for a given edge count
	function automatic logic word_bit(input logic [15:0] w,
		input asr_cnt_t idx);
		word_bit = w[4'hF - idx[3:0]];
	endfunction

endpackage

// ==== hw/asr_if.sv ====
// Purpose: Pin-level link between converter readout and its host
// Assumes: Host is the only clock source on the link
// Notes: Undriven data line resolves low
`timescale 1ns/1ps
interface asr_if;
	logic serial_clock_in;
	logic convert_start_n;
	logic serial_data_out;
	logic serial_data_oe;
	logic serial_data_line;

	assign serial_data_line = serial_data_oe & serial_data_out;

	modport dev (
		input serial_clock_in,
		input convert_start_n,
		output serial_data_out,
		output serial_data_oe
	);
	modport host (
		output serial_clock_in,
		output convert_start_n,
		input serial_data_line
	);
endinterface

// ==== hw/asr_sync.sv ====
// Purpose: Two flip-flop level synchroniser
// Assumes: Input is a slow level or toggle
// Notes: First stage feeds only the second
`timescale 1ns/1ps
module asr_sync #(
	parameter logic RST_VAL = 1'b0
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic d,
	output logic q
);
	logic meta_r;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			meta_r <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule // asr_sync

// ==== hw/asr_host.sv ====
// Purpose: Host end: starts conversions and reads the 16-bit word
// Assumes: Single converter on the link
// Notes: Serial clock comes from a divider of core_clk
`timescale 1ns/1ps
module asr_host (
	input wire logic core_clk,
	input wire logic nrst,
	asr_if.host lnk,
	input wire logic conv_req,
	input wire logic read_req,
	input wire logic dev_select,
	output logic conv_done,
	output logic rd_valid,
	output logic [11:0] rd_data,
	output logic rd_lead_err
);

	// ---------------------------------------------------------------
	// Data line capture
	// ---------------------------------------------------------------
	logic sd_s;

	asr_sync #(.RST_VAL(1'b0)) u_sync_sd (
		.clk(core_clk),
		.nrst(nrst),
		.d(lnk.serial_data_line),
		.q(sd_s)
	);

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	asr_pkg::asr_hst_t st_r;
	asr_pkg::asr_tmr_t div_r;
	asr_pkg::asr_cnt_t bit_r;
	logic [15:0] sh_r;
	logic sclk_r;
	logic cs_n_r;

	wire tick = (div_r == asr_pkg::TMR_ZERO);
	wire last_bit = (bit_r == asr_pkg::FRAME_END);
	wire [15:0] sh_nxt = {sh_r[14:0], sd_s};

	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			st_r <= asr_pkg::HS_IDLE;
			div_r <= asr_pkg::TMR_ZERO;
			bit_r <= asr_pkg::CNT_ZERO;
			sh_r <= asr_pkg::WORD_RST;
			sclk_r <= 1'b0;
			cs_n_r <= 1'b1;
			conv_done <= 1'b0;
			rd_valid <= 1'b0;
			rd_data <= asr_pkg::RES_RST;
			rd_lead_err <= 1'b0;
		end else begin
			conv_done <= 1'b0;
			rd_valid <= 1'b0;
			if (!tick) begin
				div_r <= div_r - 10'h001;
			end
			case (st_r)
			asr_pkg::HS_IDLE: begin
				// Start fall only here, with the clock parked low
				if (conv_req) begin
					cs_n_r <= 1'b0; // [R8] [R17]
					div_r <= asr_pkg::CS_LOW_LOAD; // [R13] [R14]
					st_r <= asr_pkg::HS_CNV;
				end else if (read_req && dev_select) begin
					sclk_r <= 1'b1; // [R19] [R18]
					div_r <= asr_pkg::HALF_LOAD; // [R23]
					bit_r <= asr_pkg::CNT_ZERO;
					st_r <= asr_pkg::HS_HI;
				end
			end
			asr_pkg::HS_CNV: begin
				if (tick) begin
					cs_n_r <= 1'b1;
					div_r <= asr_pkg::CONV_LOAD;
					st_r <= asr_pkg::HS_WAIT;
				end
			end
			asr_pkg::HS_WAIT: begin
				// Completion is timed from our own start rise
				if (tick) begin
					conv_done <= 1'b1; // [R21]
					st_r <= asr_pkg::HS_IDLE;
				end
			end
			asr_pkg::HS_HI: begin
				if (tick) begin
					sclk_r <= 1'b0; // [R20]
					sh_r <= sh_nxt; // [R1]
					bit_r <= bit_r + asr_pkg::CNT_ONE;
					div_r <= asr_pkg::HALF_LOAD;
					st_r <= asr_pkg::HS_LO;
				end
			end
			asr_pkg::HS_LO: begin
				if (tick && last_bit) begin
					rd_valid <= 1'b1; // [R2]
					rd_data <= sh_r[11:0];
					rd_lead_err <= |sh_r[15:12];
					st_r <= asr_pkg::HS_IDLE; // [R6]
				end else if (tick) begin
					sclk_r <= 1'b1; // [R9]
					div_r <= asr_pkg::HALF_LOAD;
					st_r <= asr_pkg::HS_HI;
				end
			end
			default: begin
				sclk_r <= 1'b0;
				cs_n_r <= 1'b1;
				st_r <= asr_pkg::HS_IDLE;
			end
			endcase
		end
	end

	assign lnk.serial_clock_in = sclk_r;
	assign lnk.convert_start_n = cs_n_r;

endmodule // asr_host

// ==== verification/asr_properties.sv ====
// Purpose: Timing checks on the link between the two readout ends
// Assumes: Host end makes the serial clock from core_clk
// Notes: Fall count presumes whole reads on this link
`timescale 1ns/1ps
module asr_properties (
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic serial_clock_in,
	input wire logic convert_start_n,
	input wire logic serial_data_out,
	input wire logic serial_data_oe
);
	// ------------------------------------------------------------
	// Helper counters
	// ------------------------------------------------------------
	logic sclk_r;
	logic [3:0] falls_r;
	logic [3:0] falls_nxt;
	logic [7:0] low_r;
	logic [7:0] low_nxt;
	wire logic fall = sclk_r & ~serial_clock_in;
	assign falls_nxt = fall ? falls_r + 4'h1 : falls_r;
	// Saturates so a long start pulse cannot wrap to a short one
	assign low_nxt = convert_start_n ? 8'h00 :
		(low_r == 8'hFF ? low_r : low_r + 8'h01);
	always_ff @(posedge core_clk or negedge nrst) begin
		if (!nrst) begin
			sclk_r <= 1'b0;
			falls_r <= 4'h0;
			low_r <= 8'h00;
		end else begin
			sclk_r <= serial_clock_in;
			falls_r <= falls_nxt;
			low_r <= low_nxt;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!nrst);
	// ------------------------------------------------------------
	// Link properties
	// ------------------------------------------------------------
	property p_shift_rise;
		$rose(serial_clock_in) |-> serial_data_oe;
	endproperty
	a_shift_rise: assert property (p_shift_rise)
		else $error("data line not driven after rise");
	property p_data_hold;
		serial_clock_in && sclk_r |-> $stable(serial_data_out);
	endproperty
	a_data_hold: assert property (p_data_hold)
		else $error("data moved while clock high");
	property p_release;
		fall && falls_r == 4'hF |-> !serial_data_oe;
	endproperty
	a_release: assert property (p_release)
		else $error("data line driven after last fall");
	property p_park;
		fall && falls_r == 4'hF |=> !serial_clock_in [*8];
	endproperty
	a_park: assert property (p_park)
		else $error("clock not parked after word");
	property p_sclk_hi;
		$rose(serial_clock_in) |=> serial_clock_in [*6];
	endproperty
	a_sclk_hi: assert property (p_sclk_hi)
		else $error("clock high phase too short");
	property p_sclk_lo;
		fall && falls_r != 4'hF |=> !serial_clock_in [*6];
	endproperty
	a_sclk_lo: assert property (p_sclk_lo)
		else $error("clock low phase too short");
	property p_start_quiet;
		!convert_start_n |-> !serial_clock_in;
	endproperty
	a_start_quiet: assert property (p_start_quiet)
		else $error("clock active while start low");
	property p_start_width;
		$rose(convert_start_n) |-> low_r > 8'h95;
	endproperty
	a_start_width: assert property (p_start_width)
		else $error("start pulse too short");
endmodule // asr_properties

// ==== verification/testbench.sv ====
// Purpose: Bench for both readout ends plus a bench-driven second link
// Assumes: Second link clock is made here at 125 ns
// Notes: Second link breaks host habits on purpose
`timescale 1ns/1ps
module testbench;
	logic core_clk = 1'b0;
	logic nrst = 1'b1;
	logic conv_req = 1'b0;
	logic read_req = 1'b0;
	logic dev_select = 1'b1;
	logic [11:0] res = 12'h000;
	logic conv_done, rd_valid, rd_lead_err, g;
	logic [11:0] rd_data;
	logic [15:0] w = 16'h0000;
	logic conv_a, conv_b, wl_a, wl_b;
	int loads = 0;
	int conv_cyc = 0;
	int fails = 0;
	int samples_checked = 0;
	int cyc = 0;
	asr_if lnk ();
	asr_if lnk_b ();
	asr_dev u_asr_dev (.core_clk(core_clk), .nrst(nrst), .lnk(lnk.dev),
		.result_in(res), .converting(conv_a), .word_loaded(wl_a));
	asr_dev u_asr_dev_b (.core_clk(core_clk), .nrst(nrst),
		.lnk(lnk_b.dev), .result_in(res), .converting(conv_b),
		.word_loaded(wl_b));
	asr_host u_asr_host (.core_clk(core_clk), .nrst(nrst),
		.lnk(lnk.host), .conv_req(conv_req), .read_req(read_req),
		.dev_select(dev_select), .conv_done(conv_done),
		.rd_valid(rd_valid), .rd_data(rd_data), .rd_lead_err(rd_lead_err));
	asr_properties u_asr_properties (.core_clk(core_clk), .nrst(nrst),
		.serial_clock_in(lnk.serial_clock_in),
		.convert_start_n(lnk.convert_start_n),
		.serial_data_out(lnk.serial_data_out),
		.serial_data_oe(lnk.serial_data_oe));
	always #5 core_clk = ~core_clk;
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic host_op(input logic cv, input logic sel, output logic got);
		got = 1'b0;
		dev_select <= sel;
		conv_req <= cv;
		read_req <= !cv;
		@(posedge core_clk);
		conv_req <= 1'b0;
		read_req <= 1'b0;
		repeat (900) begin
			@(posedge core_clk);
			if ((cv ? conv_done : rd_valid) === 1'b1) begin
				got = 1'b1;
				break;
			end
		end
	endtask
	task automatic host_word(input logic [11:0] r);
		res <= r;
		host_op(1'b1, 1'b1, g);
		check({15'h0, g}, 16'h0001);
		repeat (20) @(posedge core_clk);
		host_op(1'b0, 1'b1, g);
		check({15'h0, g}, 16'h0001);
		check({3'h0, rd_lead_err, rd_data}, {4'h0, r});
	endtask
	// Bench link: phase set 1.25 ns after a core_clk falling edge, sampled before each fall.
	// Edges stay off core_clk rising edges so no synchroniser races.
	task automatic pulses(input int n);
		@(negedge core_clk);
		#1.25;
		repeat (n) begin
			#62.5 lnk_b.serial_clock_in = 1'b1;
			#62.5 w = {w[14:0], lnk_b.serial_data_line};
			lnk_b.serial_clock_in = 1'b0;
		end
		#20;
	endtask
	task automatic start_b(input int low_ns);
		@(negedge core_clk);
		#100 lnk_b.convert_start_n = 1'b0;
		#(low_ns) lnk_b.convert_start_n = 1'b1;
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	initial begin
		lnk_b.serial_clock_in = 1'b0;
		lnk_b.convert_start_n = 1'b1;
		// A real falling edge, so every asynchronous reset takes effect
		#1 nrst = 1'b0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		repeat (3) @(posedge core_clk);
		host_word(12'hA5C);
		host_word(12'h3F1);
		host_op(1'b0, 1'b0, g);
		check({15'h0, g}, 16'h0000);
		res <= 12'h5A3;
		start_b(100);
		#7000;
		pulses(16);
		check(w, 16'h05A3);
		check({15'h0, lnk_b.serial_data_oe}, 16'h0000);
		res <= 12'hC3E;
		start_b(100);
		pulses(8);
		#7000;
		pulses(8);
		check(w, 16'h05A3);
		#500;
		pulses(16);
		check(w, 16'h0C3E);
		res <= 12'h7E1;
		start_b(100);
		pulses(4);
		#7000;
		start_b(1600);
		pulses(16);
		check(w, 16'h07E1);
		#7000;
		pulses(17);
		#300;
		check({15'h0, lnk_b.serial_data_oe}, 16'h0001);
		start_b(1600);
		#7000;
		pulses(16);
		check(w, 16'h07E1);
		check({15'h0, lnk_b.serial_data_oe}, 16'h0000);
		// Two loads on the host link, five on the bench link
		check(16'(loads), 16'h0007);
		check(16'(conv_cyc), 16'(7 * asr_pkg::CONV_CYC));
		conclude();
	end
	// Hang guard well above the expected run of about 8200 cycles
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		loads <= loads + wl_a + wl_b;
		conv_cyc <= conv_cyc + conv_a + conv_b;
		if (cyc == 30000) begin
			fails++;
			conclude();
		end
	end
endmodule // testbench
